// ---- dv/pmd_top_test.sv ----
// Purpose: self-checking bench of the disable bank over apb
// Assumes: offsets and masks from pmd_regs.svh
// Notes: driver queues expected answers, a watcher pops them per completion
`timescale 1ns/1ps
`include "pmd_regs.svh"
module pmd_top_test;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [`PMD_ADDR_W-1:0] paddr = '0;
	logic [`PMD_DATA_W-1:0] pwdata = '0;
	logic [3:0] pstrb = '0;
	logic pready, pslverr;
	logic [`PMD_DATA_W-1:0] prdata;
	wire [7:0] offs;
	wire [41:0] outs = {pready, pslverr, prdata, offs};
	logic [15:0] m [3];
	logic [15:0] mk [3] = '{`PMD_MASK_CMP_I2C, `PMD_MASK_REFCLK, `PMD_MASK_PWM};
	logic [40:0] notes [$], cur;
	logic look = 0;
	int failures = 0, compares = 0, seed = 32'h6b1db07d;
	pmd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .comparator_off(offs[7]),
		.second_i2c_off(offs[6]), .ref_clock_out_off(offs[5]), .pwm_gen5_off(offs[4]),
		.pwm_gen4_off(offs[3]), .pwm_gen3_off(offs[2]), .pwm_gen2_off(offs[1]),
		.pwm_gen1_off(offs[0]));
	initial begin
		forever #25 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(string what, logic [41:0] e, logic [41:0] s);
		compares++;
		if (e !== s) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, e, s);
		end
	endtask
	// watcher: a note per completion; one cycle on, answer gone, outputs updated
	always @(posedge pclk) begin
		if (look)
			chk("outputs", {34'h0, cur[40:33]}, outs);
		look = 0;
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0)
				chk("unexpected completion", 42'h0, 42'h1);
			else begin
				cur = notes.pop_front();
				chk("pslverr,prdata", {9'h0, cur[32:0]}, {9'h0, outs[40:8]});
				look = 1;
			end
		end
	end
	// called just after an edge; b keeps psel up for a setup right behind
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s, logic b = 0);
		int n;
		logic hit;
		logic [1:0] k;
		logic [15:0] bm;
		logic [32:0] ans;
		k = a[3:2];
		hit = (a < `PMD_OFF_PWM + 12'h004) && (a[1:0] == 2'h0);
		bm = {{8{s[1]}}, {8{s[0]}}};
		ans = !hit ? {1'b1, 32'h0} : (w ? 33'h0 : {17'h0, m[k]});
		if (hit && w)
			m[k] = (m[k] & ~bm) | (d[15:0] & bm & mk[k]);
		notes.push_back({m[0][10], m[0][1], m[1][3], m[2][12:8], ans});
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= w ? s : 4'h0;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			report_and_stop();
		end
		if (!b) begin
			psel <= 0;
			penable <= 0;
			@(posedge pclk);
		end
	endtask
	task automatic read_all();
		for (int i = 0; i < 3; i++)
			xfer(1'b0, 12'(i * 4), 32'h0, 4'h0, i < 2);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		m = '{16'h0, 16'h0, 16'h0};
		repeat (6) @(posedge pclk);
		chk("reset", 42'h0, outs);
		presetn <= 1;
		read_all();
		for (int i = 0; i < 3; i++)
			xfer(1, 12'(i * 4), 32'hffffffff, 4'hf, 1);
		read_all();
		xfer(1, `PMD_OFF_PWM, 32'h0, 4'h1);
		xfer(0, `PMD_OFF_PWM, 32'h0, 4'h0);
		xfer(1, `PMD_OFF_PWM, 32'h00001500, 4'h2);
		xfer(1, `PMD_OFF_REFCLK, 32'hfffffff7, 4'hf);
		xfer(1, `PMD_OFF_CMP_I2C, 32'h00000400, 4'h3);
		xfer(1, 12'h00c, 32'hffffffff, 4'hf);
		xfer(0, 12'hffc, 32'h0, 4'h0);
		read_all();
		repeat (40)
			xfer(1'($random(seed)), 12'(($random(seed) & 3) * 4), $random(seed),
				4'($random(seed)), 1'($random(seed)));
		read_all();
		xfer(1, `PMD_OFF_PWM, 32'h00001f00, 4'h2);
		// mid-run reset returns every control to enabled
		presetn <= 0;
		m = '{16'h0, 16'h0, 16'h0};
		@(posedge pclk);
		chk("reset", 42'h0, outs);
		presetn <= 1;
		read_all();
		repeat (2) @(posedge pclk);
		report_and_stop();
	end
endmodule

// ---- hdl/pmd_ctrl_word.sv ----
// Purpose: one 16-bit disable control word with byte lanes
// Assumes: wr_en is a one-cycle pulse on the completing apb edge
// Notes: bits outside MASK never store, so they always read zero
`timescale 1ns/1ps
`include "pmd_regs.svh"
module pmd_ctrl_word #(
	parameter logic [`PMD_REG_W-1:0] MASK = `PMD_MASK_NONE
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [`PMD_REG_W-1:0] wdata,
	input wire logic [1:0] be,
	output logic [`PMD_REG_W-1:0] q_r
);
	logic [`PMD_REG_W-1:0] lane_mask;
	logic [`PMD_REG_W-1:0] q_nxt;

	always_comb begin
		lane_mask = {{8{be[1]}}, {8{be[0]}}} & MASK;
		q_nxt = (q_r & ~lane_mask) | (wdata & lane_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= `PMD_RESET_VALUE;
		end else if (wr_en) begin
			q_r <= q_nxt;
		end
	end
endmodule

// ---- hdl/pmd_pkg.sv ----
// Purpose: shared types of the peripheral disable bank
// Assumes: constants come from pmd_regs.svh
// Notes: no process here
`include "pmd_regs.svh"
package pmd_pkg;
	typedef struct packed {
		logic [`PMD_ADDR_W-1:0] addr;
		logic write;
		logic [`PMD_DATA_W-1:0] wdata;
		logic [3:0] strb;
	} pmd_apb_req_t;

	typedef logic [1:0] pmd_idx_t;
endpackage

// ---- hdl/pmd_regs.svh ----
// Purpose: offsets, masks, field positions and reset values of the disable bank
// Assumes: 32-bit apb data, registers in the low 16 bits of each word
// Notes: definitions only
`ifndef PMD_REGS_SVH
`define PMD_REGS_SVH

`define PMD_ADDR_W 12
`define PMD_DATA_W 32
`define PMD_REG_W 16
`define PMD_NUM_REGS 3

`define PMD_OFF_CMP_I2C 12'h000
`define PMD_OFF_REFCLK 12'h004
`define PMD_OFF_PWM 12'h008

`define PMD_IDX_CMP_I2C 2'h0
`define PMD_IDX_REFCLK 2'h1
`define PMD_IDX_PWM 2'h2
`define PMD_IDX_NONE 2'h3

`define PMD_MASK_CMP_I2C 16'h0402
`define PMD_MASK_REFCLK 16'h0008
`define PMD_MASK_PWM 16'h1f00
`define PMD_MASK_NONE 16'h0000

`define PMD_RESET_VALUE 16'h0000

`define PMD_BIT_CMP 10
`define PMD_BIT_I2C2 1
`define PMD_BIT_REFCLK 3
`define PMD_BIT_PWM1 8
`define PMD_BIT_PWM2 9
`define PMD_BIT_PWM3 10
`define PMD_BIT_PWM4 11
`define PMD_BIT_PWM5 12

`endif

// ---- hdl/pmd_top.sv ----
// Purpose: apb slave holding the peripheral module disable controls
// Assumes: one clock pclk, asynchronous active-low presetn
// Notes: one wait-free access cycle; unmapped addresses answer pslverr
//
// Contract
// RULE1 - reference clock bit 3 set disables it
// RULE2 - reference clock bit 3 clear keeps enabled
// RULE3 - pwm bits 12..8 disable generators 5..1
// RULE4 - unimplemented bits read zero, ignore writes
// RULE5 - bit 10 comparator off, bit 1 i2c2
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "pmd_regs.svh"
module pmd_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`PMD_ADDR_W-1:0] paddr,
	input wire logic [`PMD_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [`PMD_DATA_W-1:0] prdata,
	output logic pslverr,
	output logic comparator_off,
	output logic second_i2c_off,
	output logic ref_clock_out_off,
	output logic pwm_gen1_off,
	output logic pwm_gen2_off,
	output logic pwm_gen3_off,
	output logic pwm_gen4_off,
	output logic pwm_gen5_off
);
	////////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic pmd_pkg::pmd_idx_t pmd_decode(input logic [`PMD_ADDR_W-1:0] a);
		case (a)
			`PMD_OFF_CMP_I2C: pmd_decode = `PMD_IDX_CMP_I2C;
			`PMD_OFF_REFCLK: pmd_decode = `PMD_IDX_REFCLK;
			`PMD_OFF_PWM: pmd_decode = `PMD_IDX_PWM;
			default: pmd_decode = `PMD_IDX_NONE;
		endcase
	endfunction

	function automatic logic [`PMD_REG_W-1:0] pmd_mask(input pmd_pkg::pmd_idx_t i);
		case (i)
			`PMD_IDX_CMP_I2C: pmd_mask = `PMD_MASK_CMP_I2C;
			`PMD_IDX_REFCLK: pmd_mask = `PMD_MASK_REFCLK;
			`PMD_IDX_PWM: pmd_mask = `PMD_MASK_PWM;
			default: pmd_mask = `PMD_MASK_NONE;
		endcase
	endfunction

	pmd_pkg::pmd_apb_req_t req;
	pmd_pkg::pmd_idx_t req_idx;
	logic setup_phase;
	logic access_done;
	logic pready_r;
	logic [`PMD_DATA_W-1:0] prdata_r;
	logic pslverr_r;
	logic [`PMD_REG_W-1:0] word_q [`PMD_NUM_REGS];
	logic [`PMD_DATA_W-1:0] rd_nxt;

	always_comb begin
		req.addr = paddr;
		req.write = pwrite;
		req.wdata = pwdata;
		req.strb = pstrb;
		req_idx = pmd_decode(req.addr);
		setup_phase = psel && !penable;
		access_done = psel && penable && pready_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// control words

	localparam logic [`PMD_REG_W-1:0] WORD_MASK [`PMD_NUM_REGS] = '{
		`PMD_MASK_CMP_I2C, `PMD_MASK_REFCLK, `PMD_MASK_PWM
	};

	genvar gi;
	generate
		for (gi = 0; gi < `PMD_NUM_REGS; gi++) begin : g_word
			logic wr_hit;
			assign wr_hit = access_done && req.write && (req_idx == 2'(gi));
			// mask stops unimplemented positions from storing
			pmd_ctrl_word #(
				.MASK(WORD_MASK[gi])
			) u_word (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(wr_hit),
				.wdata(req.wdata[`PMD_REG_W-1:0]),
				.be(req.strb[1:0]),
				.q_r(word_q[gi])
			); // RULE4
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// apb answer

	always_comb begin
		rd_nxt = '0;
		if (req_idx != `PMD_IDX_NONE) begin
			rd_nxt = {{(`PMD_DATA_W-`PMD_REG_W){1'b0}}, word_q[req_idx] & pmd_mask(req_idx)}; // RULE4
		end
	end

	// answer is prepared in setup so every output stays a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
		end else begin
			pready_r <= setup_phase;
		end
	end

	// limitation: a setup abandoned before its access phase leaves the answer standing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else if (setup_phase) begin
			prdata_r <= req.write ? '0 : rd_nxt;
			pslverr_r <= (req_idx == `PMD_IDX_NONE);
		end else if (access_done) begin
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end
	end

	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////////////
	// disable outputs, each a stored bit

	assign comparator_off = word_q[`PMD_IDX_CMP_I2C][`PMD_BIT_CMP]; // RULE5
	assign second_i2c_off = word_q[`PMD_IDX_CMP_I2C][`PMD_BIT_I2C2]; // RULE5
	assign ref_clock_out_off = word_q[`PMD_IDX_REFCLK][`PMD_BIT_REFCLK]; // RULE1 RULE2
	assign pwm_gen1_off = word_q[`PMD_IDX_PWM][`PMD_BIT_PWM1]; // RULE3
	assign pwm_gen2_off = word_q[`PMD_IDX_PWM][`PMD_BIT_PWM2]; // RULE3
	assign pwm_gen3_off = word_q[`PMD_IDX_PWM][`PMD_BIT_PWM3]; // RULE3
	assign pwm_gen4_off = word_q[`PMD_IDX_PWM][`PMD_BIT_PWM4]; // RULE3
	assign pwm_gen5_off = word_q[`PMD_IDX_PWM][`PMD_BIT_PWM5]; // RULE3

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_ref;
	logic wr_pwm;
	logic wr_cmp;
	logic [4:0] pwm_vec;
	logic [`PMD_NUM_REGS*`PMD_REG_W-1:0] all_words;
	assign wr_ref = access_done && req.write && req_idx == `PMD_IDX_REFCLK && req.strb[0];
	assign wr_pwm = access_done && req.write && req_idx == `PMD_IDX_PWM && req.strb[1];
	assign wr_cmp = access_done && req.write && req_idx == `PMD_IDX_CMP_I2C;
	assign pwm_vec = {pwm_gen5_off, pwm_gen4_off, pwm_gen3_off, pwm_gen2_off, pwm_gen1_off};
	assign all_words = {word_q[`PMD_IDX_PWM], word_q[`PMD_IDX_REFCLK], word_q[`PMD_IDX_CMP_I2C]};

	a_refclk_disable: assert property ( // RULE1
		wr_ref && req.wdata[`PMD_BIT_REFCLK] |=> ref_clock_out_off
	) else $error("reference clock not disabled after write of one");

	a_refclk_enable: assert property ( // RULE2
		wr_ref && !req.wdata[`PMD_BIT_REFCLK] |=> !ref_clock_out_off [*2]
	) else $error("reference clock not kept enabled after write of zero");

	a_pwm_follow: assert property ( // RULE3
		wr_pwm |=> pwm_vec == $past(req.wdata[`PMD_BIT_PWM5:`PMD_BIT_PWM1])
	) else $error("pwm disables do not match written bits");

	a_pwm_hold: assert property ( // RULE3
		!wr_pwm |=> $stable(pwm_vec)
	) else $error("pwm disables changed without a write");

	a_unimpl_zero: assert property ( // RULE4
		access_done && !req.write && req_idx != `PMD_IDX_NONE
			|-> (prdata_r[`PMD_REG_W-1:0] & ~pmd_mask(req_idx)) == '0
			&& prdata_r[`PMD_DATA_W-1:`PMD_REG_W] == '0
	) else $error("unimplemented bits read as one");

	a_unmapped_err: assert property ( // RULE4
		setup_phase && req_idx == `PMD_IDX_NONE |=> pready_r && pslverr_r && prdata_r == '0
	) else $error("unmapped access not answered with error");

	a_cmp_follow: assert property ( // RULE5
		wr_cmp && req.strb[1] |=> comparator_off == $past(req.wdata[`PMD_BIT_CMP])
	) else $error("comparator disable does not follow write");

	a_i2c_follow: assert property ( // RULE5
		wr_cmp && req.strb[0] |=> second_i2c_off == $past(req.wdata[`PMD_BIT_I2C2])
	) else $error("second i2c disable does not follow write");

	a_ready_timing: assert property (
		setup_phase |=> pready_r ##1 !pready_r
	) else $error("access phase not exactly one cycle");

	a_unmapped_write: assert property ( // RULE4
		access_done && req.write && req_idx == `PMD_IDX_NONE |=> $stable(all_words)
	) else $error("write to unmapped address changed a control");

	a_ref_hold: assert property ( // RULE2
		!wr_ref |=> $stable(ref_clock_out_off)
	) else $error("reference clock disable changed without a write");

	// answer must not linger into idle cycles, or a later read could take it
	a_idle_quiet: assert property (
		!psel |=> !pready_r && !pslverr_r && prdata_r == '0
	) else $error("apb answer standing while not selected");

	c_refclk_off: cover property (wr_ref ##1 ref_clock_out_off);
	c_all_pwm_off: cover property (wr_pwm ##1 pwm_vec == 5'h1f);
	c_cmp_read: cover property (access_done && !req.write && req_idx == `PMD_IDX_CMP_I2C);
	c_back_to_back: cover property (access_done ##2 access_done);
	c_unmapped: cover property (setup_phase && req_idx == `PMD_IDX_NONE);
endmodule
